// File: pkg/fault_pkg.sv
`default_nettype none
package fault_pkg;
  // Fault codes.
  localparam logic [7:0] code_none = 8'h00;
  localparam logic [7:0] code_supply = 8'h01;
  localparam logic [7:0] code_hw_enable = 8'h0f;
  localparam logic [7:0] code_dc_under = 8'h14;
  localparam logic [7:0] code_dc_over = 8'h15;
  localparam logic [7:0] code_blocked = 8'h16;
  localparam logic [7:0] code_tracking = 8'h17;
  localparam logic [7:0] code_ext_supply = 8'h18;
  localparam logic [7:0] code_rail0 = 8'h19;
  localparam logic [7:0] code_mains = 8'h1d;
  localparam logic [7:0] code_thermal = 8'h1e;
  localparam logic [7:0] code_listing = 8'h1f;
  localparam logic [7:0] code_asym = 8'h26;
  localparam logic [7:0] code_commut = 8'h27;
  localparam logic [7:0] code_enc2 = 8'h2a;
  localparam logic [7:0] code_lost = 8'h2b;
  localparam logic [7:0] code_passive = 8'h2c;
  localparam logic [7:0] code_busoff = 8'h2d;
  // Bus controller error count thresholds.
  localparam logic [7:0] passive_limit = 8'h7f;
  localparam logic [7:0] busoff_limit = 8'hff;
  // Fault bit positions in the status word.
  localparam int n_faults = 18;
  localparam int b_dc_under = 0;
  localparam int b_dc_over = 1;
  localparam int b_blocked = 2;
  localparam int b_tracking = 3;
  localparam int b_ext_supply = 4;
  localparam int b_rail0 = 5;
  localparam int b_mains = 8;
  localparam int b_thermal = 9;
  localparam int b_listing = 10;
  localparam int b_asym = 11;
  localparam int b_commut = 12;
  localparam int b_enc2 = 13;
  localparam int b_lost = 14;
  localparam int b_passive = 15;
  localparam int b_busoff = 16;
  localparam int b_hw_enable = 17;
  // Register byte addresses.
  localparam logic [7:0] addr_status = 8'h00;
  localparam logic [7:0] addr_mask = 8'h04;
  localparam logic [7:0] addr_code = 8'h08;
  localparam logic [7:0] addr_ctrl = 8'h0c;
  localparam logic [7:0] addr_blk_time = 8'h10;
  localparam logic [7:0] addr_trk_time = 8'h14;
  localparam logic [7:0] addr_lost_max = 8'h18;
  // Reset values, bus response codes and reaction classes.
  localparam logic [17:0] mask_reset = 18'h00000;
  localparam logic [15:0] blk_time_reset = 16'h03e8;
  localparam logic [15:0] trk_time_reset = 16'h0064;
  localparam logic [7:0] lost_max_reset = 8'h0a;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
  typedef enum {react_none, react_ramp, react_power_off} reaction_t;
  // Condition flags from measurement and control logic.
  typedef struct packed {
    logic dc_below_min;
    logic dc_above_max;
    logic speed_zero;
    logic track_over;
    logic ext_supply_low;
    logic [2:0] rail_low;
    logic mains_high;
    logic thermal_over;
    logic listing_over;
    logic enc_asym;
    logic commut_fail;
    logic enc2_fault;
    logic lost_xfer;
    logic [7:0] bus_err_cnt;
  } cond_t;
endpackage : fault_pkg
`default_nettype wire

// File: core/drive_fault_supervisor.sv
// Operation
// - DC link below the minimum trip value raises code 20 with an emergency ramp stop.
// - DC link above its maximum raises code 21 with an emergency ramp stop.
// - Speed stuck at zero past the blocking time raises code 22 and removes power.
// - Following error over its limit for the tracking window raises code 23 with a ramp stop.
// - External logic supply under 18 V raises code 24 plus supply code 1 and removes power.
// - An internal rail low raises code 25 to 27 plus supply code 1 and removes power.
// - Averaged mains power too high raises code 29 and removes power.
// - Motor thermal model over its maximum raises code 30 and removes power.
// - Listing overload limit exceeded raises code 31 and removes power.
// - Sine and cosine amplitude mismatch raises code 38 and removes power.
// - Failed commutation offset measurement raises code 39 and removes power.
// - Fitted second encoder fault raises code 42 and removes power.
// - Lost cyclic transfers reaching the maximum raise code 43 with a ramp stop.
// - Bus error count above 127 raises code 44, reaching 255 raises code 45, both ramp stops.
// - Software enable without hardware enable raises code 15 and removes power.
`timescale 1ns/1ps
`default_nettype none
module drive_fault_supervisor #(
  parameter int time_w = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire fault_pkg::cond_t cond,
  input wire logic second_encoder_option,
  input wire logic hw_enable,
  input wire logic fault_ack,
  output logic drive_enable_ff,
  output logic ramp_stop_ff,
  output logic power_off_ff,
  output logic [7:0] fault_code_ff,
  output logic supply_fault_ff,
  output logic irq_ff
);

  ////////////////////////////////////////////////////////////////////////////
  logic [fault_pkg::n_faults-1:0] status_ff;
  logic [fault_pkg::n_faults-1:0] mask_ff;
  logic [time_w-1:0] blk_time_ff;
  logic [time_w-1:0] trk_time_ff;
  logic [7:0] lost_max_ff;
  logic sw_enable_ff;
  logic [time_w-1:0] blk_cnt_ff;
  logic [time_w-1:0] trk_cnt_ff;
  logic [7:0] lost_cnt_ff;
  logic [fault_pkg::n_faults-1:0] events;
  logic aw_ok;
  logic w_ok;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic do_write;
  logic [fault_pkg::n_faults-1:0] w1c;
  logic any_fault;
  logic [7:0] nxt_code;
  fault_pkg::reaction_t nxt_react;

  ////////////////////////////////////////////////////////////////////////////
  // Timers for the conditions that must persist before they trip.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_cnt_ff <= '0;
    end else if (!cond.speed_zero || !drive_enable_ff) begin
      blk_cnt_ff <= '0;
    end else if (blk_cnt_ff != blk_time_ff) begin
      blk_cnt_ff <= blk_cnt_ff + time_w'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trk_cnt_ff <= '0;
    end else if (!cond.track_over) begin
      trk_cnt_ff <= '0;
    end else if (trk_cnt_ff != trk_time_ff) begin
      trk_cnt_ff <= trk_cnt_ff + time_w'(1);
    end
  end

  // Each cycle with lost_xfer high counts once, up to lost_max_ff; the count restarts on acknowledge.
  always_ff @(posedge aclk) begin
    if (!aresetn || fault_ack) begin
      lost_cnt_ff <= '0;
    end else if (cond.lost_xfer && lost_cnt_ff != lost_max_ff) begin
      lost_cnt_ff <= lost_cnt_ff + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    events = '0;
    events[fault_pkg::b_dc_under] = cond.dc_below_min;
    events[fault_pkg::b_dc_over] = cond.dc_above_max;
    events[fault_pkg::b_blocked] = drive_enable_ff && cond.speed_zero && blk_cnt_ff == blk_time_ff;
    events[fault_pkg::b_tracking] = cond.track_over && trk_cnt_ff == trk_time_ff;
    events[fault_pkg::b_ext_supply] = cond.ext_supply_low;
    events[fault_pkg::b_rail0 +: 3] = cond.rail_low;
    events[fault_pkg::b_mains] = cond.mains_high;
    events[fault_pkg::b_thermal] = cond.thermal_over;
    events[fault_pkg::b_listing] = cond.listing_over;
    events[fault_pkg::b_asym] = cond.enc_asym;
    events[fault_pkg::b_commut] = cond.commut_fail;
    events[fault_pkg::b_enc2] = second_encoder_option && cond.enc2_fault;
    // The acknowledge restarts the count, so a count still at its maximum on that edge is stale.
    events[fault_pkg::b_lost] = !fault_ack && lost_cnt_ff == lost_max_ff;
    events[fault_pkg::b_passive] = cond.bus_err_cnt > fault_pkg::passive_limit;
    events[fault_pkg::b_busoff] = cond.bus_err_cnt == fault_pkg::busoff_limit;
    events[fault_pkg::b_hw_enable] = sw_enable_ff && !hw_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code selection: power-removal faults rank ahead of ramp faults.
  always_comb begin
    nxt_code = fault_pkg::code_none;
    nxt_react = fault_pkg::react_none;
    if (status_ff[fault_pkg::b_busoff]) begin
      nxt_code = fault_pkg::code_busoff;
      nxt_react = fault_pkg::react_ramp;
    end else if (status_ff[fault_pkg::b_passive]) begin
      nxt_code = fault_pkg::code_passive;
      nxt_react = fault_pkg::react_ramp;
    end else if (status_ff[fault_pkg::b_lost]) begin
      nxt_code = fault_pkg::code_lost;
      nxt_react = fault_pkg::react_ramp;
    end else if (status_ff[fault_pkg::b_tracking]) begin
      nxt_code = fault_pkg::code_tracking;
      nxt_react = fault_pkg::react_ramp;
    end else if (status_ff[fault_pkg::b_dc_over]) begin
      nxt_code = fault_pkg::code_dc_over;
      nxt_react = fault_pkg::react_ramp;
    end else if (status_ff[fault_pkg::b_dc_under]) begin
      nxt_code = fault_pkg::code_dc_under;
      nxt_react = fault_pkg::react_ramp;
    end
    if (status_ff[fault_pkg::b_hw_enable]) begin
      nxt_code = fault_pkg::code_hw_enable;
      nxt_react = fault_pkg::react_power_off;
    end
    if (status_ff[fault_pkg::b_enc2]) begin
      nxt_code = fault_pkg::code_enc2;
      nxt_react = fault_pkg::react_power_off;
    end
    if (status_ff[fault_pkg::b_commut]) begin
      nxt_code = fault_pkg::code_commut;
      nxt_react = fault_pkg::react_power_off;
    end
    if (status_ff[fault_pkg::b_asym]) begin
      nxt_code = fault_pkg::code_asym;
      nxt_react = fault_pkg::react_power_off;
    end
    if (status_ff[fault_pkg::b_listing]) begin
      nxt_code = fault_pkg::code_listing;
      nxt_react = fault_pkg::react_power_off;
    end
    if (status_ff[fault_pkg::b_thermal]) begin
      nxt_code = fault_pkg::code_thermal;
      nxt_react = fault_pkg::react_power_off;
    end
    if (status_ff[fault_pkg::b_mains]) begin
      nxt_code = fault_pkg::code_mains;
      nxt_react = fault_pkg::react_power_off;
    end
    if (status_ff[fault_pkg::b_blocked]) begin
      nxt_code = fault_pkg::code_blocked;
      nxt_react = fault_pkg::react_power_off;
    end
    for (int i = 2; i >= 0; i--) begin
      if (status_ff[fault_pkg::b_rail0 + i]) begin
        nxt_code = fault_pkg::code_rail0 + 8'(i);
        nxt_react = fault_pkg::react_power_off;
      end
    end
    if (status_ff[fault_pkg::b_ext_supply]) begin
      nxt_code = fault_pkg::code_ext_supply;
      nxt_react = fault_pkg::react_power_off;
    end
  end

  assign any_fault = |status_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Latched faults; a new event wins over an acknowledge or a clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= '0;
    end else if (fault_ack) begin
      status_ff <= events;
    end else begin
      status_ff <= (status_ff & ~w1c) | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_code_ff <= fault_pkg::code_none;
      ramp_stop_ff <= 1'b0;
      power_off_ff <= 1'b0;
      supply_fault_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      fault_code_ff <= nxt_code;
      ramp_stop_ff <= nxt_react == fault_pkg::react_ramp;
      power_off_ff <= nxt_react == fault_pkg::react_power_off;
      supply_fault_ff <= |status_ff[fault_pkg::b_ext_supply +: 4];
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_enable_ff <= 1'b0;
    end else begin
      drive_enable_ff <= sw_enable_ff && hw_enable && !any_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data are taken in either order.
  assign aw_ok = s_axi_awvalid && s_axi_awready;
  assign w_ok = s_axi_wvalid && s_axi_wready;
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fault_pkg::resp_okay;
      awaddr_ff <= '0;
      wdata_ff <= '0;
    end else begin
      if (aw_ok) begin
        s_axi_awready <= 1'b0;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_ok) begin
        s_axi_wready <= 1'b0;
        wdata_ff <= s_axi_wdata;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= awaddr_ff > fault_pkg::addr_lost_max ? fault_pkg::resp_slverr : fault_pkg::resp_okay;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign w1c = (do_write && awaddr_ff == fault_pkg::addr_status) ? wdata_ff[fault_pkg::n_faults-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_ff <= fault_pkg::mask_reset;
      sw_enable_ff <= 1'b0;
      blk_time_ff <= time_w'(fault_pkg::blk_time_reset);
      trk_time_ff <= time_w'(fault_pkg::trk_time_reset);
      lost_max_ff <= fault_pkg::lost_max_reset;
    end else if (do_write) begin
      case (awaddr_ff)
        fault_pkg::addr_mask: mask_ff <= wdata_ff[fault_pkg::n_faults-1:0];
        fault_pkg::addr_ctrl: sw_enable_ff <= wdata_ff[0];
        fault_pkg::addr_blk_time: blk_time_ff <= wdata_ff[time_w-1:0];
        fault_pkg::addr_trk_time: trk_time_ff <= wdata_ff[time_w-1:0];
        fault_pkg::addr_lost_max: lost_max_ff <= wdata_ff[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= fault_pkg::resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= fault_pkg::resp_okay;
      case (s_axi_araddr)
        fault_pkg::addr_status: s_axi_rdata <= 32'(status_ff);
        fault_pkg::addr_mask: s_axi_rdata <= 32'(mask_ff);
        fault_pkg::addr_code: s_axi_rdata <= {22'h000000, power_off_ff, ramp_stop_ff, fault_code_ff};
        fault_pkg::addr_ctrl: s_axi_rdata <= {30'h00000000, drive_enable_ff, sw_enable_ff};
        fault_pkg::addr_blk_time: s_axi_rdata <= 32'(blk_time_ff);
        fault_pkg::addr_trk_time: s_axi_rdata <= 32'(trk_time_ff);
        fault_pkg::addr_lost_max: s_axi_rdata <= 32'(lost_max_ff);
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= fault_pkg::resp_slverr;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : drive_fault_supervisor
`default_nettype wire

// File: sim/drive_monitor_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for the measurement logic and the supervisory controller.
module drive_monitor_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [22:0] want,
  input wire logic lost_req,
  input wire logic ack_req,
  output fault_pkg::cond_t cond,
  output logic fault_ack
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond <= '0;
      fault_ack <= 1'b0;
    end else begin
      cond <= fault_pkg::cond_t'({want[22:9], lost_req, want[7:0]});
      fault_ack <= ack_req;
    end
  end
endmodule : drive_monitor_model
`default_nettype wire

// File: sim/drive_fault_supervisor_checker.sv
`timescale 1ns/1ps
`default_nettype none
module drive_fault_supervisor_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire fault_pkg::cond_t cond,
  input wire logic fault_ack,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic drive_enable_ff,
  input wire logic ramp_stop_ff,
  input wire logic power_off_ff,
  input wire logic [7:0] fault_code_ff,
  input wire logic supply_fault_ff,
  input wire logic irq_ff
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_EXCL: assert property (!(ramp_stop_ff && power_off_ff))
    else $error("ramp and power off both active");
  AST_PWR_CODE: assert property (power_off_ff |->
    fault_code_ff inside {8'h0f, 8'h16, [8'h18:8'h1b], [8'h1d:8'h1f], 8'h26, 8'h27, 8'h2a})
    else $error("power off with a ramp class code");
  AST_RAMP_CODE: assert property (ramp_stop_ff |->
    fault_code_ff inside {8'h14, 8'h15, 8'h17, [8'h2b:8'h2d]}) else $error("ramp with a power class code");
  AST_SUPPLY: assert property ((cond.ext_supply_low || |cond.rail_low) |->
    ##2 supply_fault_ff && power_off_ff) else $error("supply fault not reported");
  AST_EXT_CODE: assert property (cond.ext_supply_low |-> ##2 fault_code_ff == 8'h18)
    else $error("external supply code wrong");
  AST_RAIL_CODE: assert property (|cond.rail_low |-> ##2 fault_code_ff inside {[8'h18:8'h1b]})
    else $error("rail code wrong");
  AST_STOP: assert property ((cond.dc_below_min || cond.dc_above_max || cond.bus_err_cnt > 8'h7f)
    |-> ##2 (ramp_stop_ff || power_off_ff) && !drive_enable_ff) else $error("no stop reaction");
  AST_HOLD: assert property ((fault_code_ff != 8'h00 && !fault_ack && !$past(fault_ack) && s_axi_wready
    && !s_axi_wvalid) |=> fault_code_ff != 8'h00) else $error("fault dropped without acknowledge");
  AST_BLOCK: assert property (fault_code_ff != 8'h00 |-> !drive_enable_ff)
    else $error("enabled while fault latched");
  cover property (ramp_stop_ff);
  cover property (power_off_ff && supply_fault_ff);
  cover property (irq_ff);
endmodule : drive_fault_supervisor_checker
`default_nettype wire

// File: sim/drive_fault_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module drive_fault_supervisor_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire fault_pkg::cond_t cond;
  wire logic fault_ack, drive_enable_ff, ramp_stop_ff, power_off_ff, supply_fault_ff, irq_ff;
  wire logic [7:0] fault_code_ff;
  logic second_encoder_option = 1'b0, hw_enable = 1'b1, lost_req = 1'b0, ack_req = 1'b0;
  logic [22:0] want = 23'h0;
  int n_mismatch = 0;
  int checked = 0;
  always #2.5 aclk = ~aclk;
  drive_monitor_model u_drive_monitor_model (.aclk, .aresetn, .want, .lost_req, .ack_req, .cond, .fault_ack);
  drive_fault_supervisor u_drive_fault_supervisor (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cond, .second_encoder_option, .hw_enable, .fault_ack, .drive_enable_ff, .ramp_stop_ff,
    .power_off_ff, .fault_code_ff, .supply_fault_ff, .irq_ff);
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc
  task automatic stall(input int n);
    if (n >= 60) begin
      n_mismatch++;
      $display("[ERR] handshake expected answer seen timeout");
      wrap_up();
    end
  endtask : stall
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 60) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        break;
      end
    end
    stall(n);
  endtask : wr
  task automatic rdr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 60) begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        break;
      end
    end
    stall(n);
  endtask : rdr
  task automatic ack_pulse;
    ack_req <= 1'b1;
    cyc(1);
    ack_req <= 1'b0;
    cyc(4);
  endtask : ack_pulse
  task automatic tf(input logic [22:0] v, input logic [7:0] c, input logic pw, input logic sp, input int w);
    want <= v;
    cyc(w);
    chk("code", {24'h0, c}, {24'h0, fault_code_ff});
    chk("class", {30'h0, pw, c != 8'h00 && !pw}, {30'h0, power_off_ff, ramp_stop_ff});
    chk("supply", {31'h0, sp}, {31'h0, supply_fault_ff});
    want <= 23'h0;
    cyc(1);
    ack_pulse();
    chk("cleared", 32'h0, {24'h0, fault_code_ff});
  endtask : tf
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    n_mismatch++;
    $display("[ERR] run expected end seen timeout");
    wrap_up();
  end
  initial begin
    cyc(6);
    aresetn <= 1'b1;
    rdr(8'h00, 32'h0, 2'b00);
    rdr(8'h04, 32'h0, 2'b00);
    rdr(8'h10, 32'h3e8, 2'b00);
    rdr(8'h14, 32'h64, 2'b00);
    rdr(8'h18, 32'ha, 2'b00);
    rdr(8'h1c, 32'h0, 2'b10);
    wr(8'h1c, 32'h1, 2'b10);
    tf(23'h400000, 8'h14, 0, 0, 4);
    tf(23'h200000, 8'h15, 0, 0, 4);
    tf(23'h040000, 8'h18, 1, 1, 4);
    tf(23'h008000, 8'h19, 1, 1, 4);
    tf(23'h010000, 8'h1a, 1, 1, 4);
    tf(23'h020000, 8'h1b, 1, 1, 4);
    tf(23'h004000, 8'h1d, 1, 0, 4);
    tf(23'h002000, 8'h1e, 1, 0, 4);
    tf(23'h001000, 8'h1f, 1, 0, 4);
    tf(23'h000800, 8'h26, 1, 0, 4);
    tf(23'h000400, 8'h27, 1, 0, 4);
    tf(23'h000200, 8'h00, 0, 0, 4);
    second_encoder_option <= 1'b1;
    tf(23'h000200, 8'h2a, 1, 0, 4);
    tf(23'h00007f, 8'h00, 0, 0, 4);
    tf(23'h000080, 8'h2c, 0, 0, 4);
    tf(23'h0000ff, 8'h2d, 0, 0, 4);
    tf(23'h440000, 8'h18, 1, 1, 4);
    // A one-cycle condition must stay latched and block enabling.
    want <= 23'h400000;
    cyc(1);
    want <= 23'h0;
    cyc(6);
    chk("latched", 32'h14, {24'h0, fault_code_ff});
    chk("irq masked", 32'h0, {31'h0, irq_ff});
    rdr(8'h00, 32'h1, 2'b00);
    rdr(8'h08, 32'h114, 2'b00);
    wr(8'h0c, 32'h1, 2'b00);
    cyc(3);
    chk("enable blocked", 32'h0, {31'h0, drive_enable_ff});
    wr(8'h04, 32'h1, 2'b00);
    cyc(3);
    chk("irq", 32'h1, {31'h0, irq_ff});
    wr(8'h00, 32'h1, 2'b00);
    cyc(3);
    chk("w1c", 32'h0, {23'h0, irq_ff, fault_code_ff});
    rdr(8'h0c, 32'h3, 2'b00);
    wr(8'h10, 32'h5, 2'b00);
    wr(8'h14, 32'h5, 2'b00);
    tf(23'h100000, 8'h00, 0, 0, 3);
    tf(23'h100000, 8'h16, 1, 0, 12);
    tf(23'h080000, 8'h00, 0, 0, 3);
    tf(23'h080000, 8'h17, 0, 0, 12);
    hw_enable <= 1'b0;
    cyc(4);
    chk("hw enable", 32'h10f, {23'h0, power_off_ff, fault_code_ff});
    wr(8'h0c, 32'h0, 2'b00);
    hw_enable <= 1'b1;
    ack_pulse();
    wr(8'h18, 32'h3, 2'b00);
    for (int i = 0; i < 3; i++) begin
      chk("lost", 32'h0, {24'h0, fault_code_ff});
      lost_req <= 1'b1;
      cyc(1);
      lost_req <= 1'b0;
      cyc(4);
    end
    chk("lost max", 32'h12b, {23'h0, ramp_stop_ff, fault_code_ff});
    ack_pulse();
    chk("lost ack", 32'h0, {24'h0, fault_code_ff});
    wrap_up();
  end
endmodule : drive_fault_supervisor_tb
bind drive_fault_supervisor drive_fault_supervisor_checker u_drive_fault_supervisor_checker (.aclk, .aresetn,
  .cond, .fault_ack, .s_axi_wvalid, .s_axi_wready, .drive_enable_ff, .ramp_stop_ff, .power_off_ff,
  .fault_code_ff, .supply_fault_ff, .irq_ff);
`default_nettype wire
